// ===== pkg/flog_pkg.sv
// ============================================================
// Shared constants, types and helpers of the fault log block.
// ============================================================
package flog_pkg;

    // ============================================================
    // Log geometry.
    // ============================================================
    localparam int LOG_LEN = 147; // Bytes returned for a present log.
    localparam int HDR_LEN = 27; // Header bytes 0 to 26 held here.
    localparam logic [7:0] LOG_LEN_BYTE = 8'(LOG_LEN); // Block length byte.
    localparam logic [7:0] EMPTY_LEN_BYTE = 8'h00; // Block length with no log.
    localparam logic [7:0] EVENT_FILL = 8'hff; // Event page bytes not kept here.
    localparam logic [4:0] HDR_LAST_IDX = 5'(HDR_LEN - 1); // Last header byte.
    localparam logic [7:0] LOG_LAST_IDX = 8'(LOG_LEN - 1); // Last log byte.
    localparam logic [7:0] HDR_LEN_BYTE = 8'(HDR_LEN); // First event page byte.

    // ============================================================
    // Up-time counter timing.
    // ============================================================
    localparam int UPTIME_W = 48; // Counter width in bits.
    localparam int UPTIME_TICK_US = 200; // Counter step in microseconds.
    localparam int CLK_MHZ = 125; // System clock rate.
    localparam int UPTIME_TICK_CYC = UPTIME_TICK_US * CLK_MHZ; // Cycles per step.

    // ============================================================
    // Die temperature window, in degrees Celsius.
    // ============================================================
    localparam int TEMP_HOT_C = 130; // Above this the force store is off.
    localparam int TEMP_COOL_C = 125; // Below this it is back on.
    localparam int LIN11_FRAC = 16; // Fraction bits of the fixed-point form.

    // ============================================================
    // Commands, telemetry and stream bytes.
    // ============================================================
    typedef enum logic [1:0] {
        FLOG_CMD_FORCE_STORE,
        FLOG_CMD_READOUT,
        FLOG_CMD_ERASE,
        FLOG_CMD_PEAK_RESET
    } flog_cmd_t;

    typedef struct packed {
        logic [15:0] vout0; // Output voltage, channel 0, mantissa only.
        logic [15:0] vout1; // Output voltage, channel 1, mantissa only.
        logic [15:0] iout0; // Output current, channel 0, 11-bit linear.
        logic [15:0] iout1; // Output current, channel 1, 11-bit linear.
        logic [15:0] vin; // Input voltage, 11-bit linear.
        logic [15:0] temp0; // External sensor 0, 11-bit linear.
        logic [15:0] temp1; // External sensor 1, 11-bit linear.
        logic [15:0] die; // Die temperature, 11-bit linear.
    } flog_tlm_t;

    typedef struct packed {
        logic [7:0] data; // Stream byte.
        logic last; // High on the final byte of a block read.
    } flog_byte_t;

    // Turns an 11-bit linear word into signed fixed point with 16 fraction
    // bits, so readings with different exponents compare correctly.
    function automatic logic signed [63:0] flog_lin11_fix(input logic [15:0] w);
        logic signed [63:0] m;
        logic [4:0] sh;
        m = 64'(signed'(w[10:0]));
        sh = {~w[15], w[14:11]};
        return m <<< sh;
    endfunction : flog_lin11_fix

endpackage : flog_pkg

// ===== src/flog_skid.sv
`timescale 1ns/1ns
// ============================================================
// Two-entry buffer on the read stream.
// ============================================================
module flog_skid
    import flog_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input flog_byte_t in_data,
    input wire logic in_valid,
    output logic in_ready,
    output flog_byte_t out_data,
    output logic out_valid,
    input wire logic out_ready
);

    flog_byte_t mem_q [2]; // Entry storage.
    logic wr_ptr_q; // Next entry to fill.
    logic rd_ptr_q; // Next entry to drain.
    logic [1:0] cnt_q; // Entries held, 0 to 2.
    wire push = in_valid && in_ready; // A byte enters.
    wire pop = out_valid && out_ready; // A byte leaves.

    // Full and empty come straight from the count, so a stalled reader
    // stops the producer after two bytes and nothing is dropped.
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_ptr_q];

    // ============================================================
    // Storage and pointers.
    // ============================================================
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and count move on every accepted push or pop.
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule : flog_skid

// ===== src/flog_core.sv
`timescale 1ns/1ns
// Behaviour
// (R1) Force store follows the fault store path.
// (R2) Force store raises vendor fault when enabled.
// (R3) Force store off above 130C until 125C.
// (R4) 48-bit up-time counter, 200us step, reset clears.
// (R5) Force store only as zero-data write.
// (R6) Present log reads length 147, 147 bytes.
// (R7) Absent log reads length zero, no data.
// (R8) Bytes 0-1 hold two-character ASCII preface.
// (R9) Bytes 2-3 hold factory identifier, high first.
// (R10) Bytes 5-10 hold timestamp, low byte first.
// (R11) Bytes 11-14 hold output voltage peaks.
// (R12) Bytes 15-18 hold output current peaks.
// (R13) Bytes 19-20 hold input voltage peak.
// (R14) Peaks restart on reset and clear command.
// (R15) Bytes 21-24 hold external temperatures.
// (R16) Bytes 25-26 hold die temperature.
// (R17) Voltage words mantissa only, bytes as sourced.
// (R18) Stored log locked until erased; here reset also clears the lock.
// (R19) Erase empties the log.
// (R20) Log bytes stream in ascending order.
module flog_core
    import flog_pkg::*;
#(
    parameter int TICK_CYCLES = UPTIME_TICK_CYC, // Clock cycles per up-time step.
    parameter logic [15:0] PREFACE = 16'h464c, // Arbitrary ASCII preface value.
    parameter logic [15:0] FACTORY_ID = 16'h0a5c // Arbitrary factory identifier.
) (
    input wire logic clk,
    input wire logic rst,
    input flog_tlm_t tlm,
    input wire logic tlm_valid,
    input wire logic fault_event,
    input wire logic [7:0] fault_source,
    input wire logic cmd_valid,
    input flog_cmd_t cmd_code,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_data_len,
    input wire logic log_enable,
    input wire logic vendor_fault_clr,
    output logic vendor_status_fault,
    output logic cmd_rejected,
    output logic log_present,
    output logic store_busy,
    output logic [UPTIME_W-1:0] uptime_stamp,
    output flog_byte_t rd_byte,
    output logic rd_valid,
    input wire logic rd_ready
);

    // ============================================================
    // Declarations.
    // ============================================================
    typedef enum {ST_IDLE, ST_WRITE} flog_store_t; // Store sequence states.
    typedef enum {RD_IDLE, RD_LEN, RD_DATA} flog_rd_t; // Block read states.

    localparam logic signed [63:0] HOT_FIX = 64'(TEMP_HOT_C) <<< LIN11_FRAC;
    localparam logic signed [63:0] COOL_FIX = 64'(TEMP_COOL_C) <<< LIN11_FRAC;
    localparam int TICK_W = $clog2(TICK_CYCLES + 1); // Prescaler width.
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    flog_store_t store_q; // Store sequence state.
    flog_rd_t rd_q; // Block read state.
    logic [7:0] log_mem [HDR_LEN]; // Nonvolatile header image.
    logic [HDR_LEN*8-1:0] snap_q; // Header frozen when the store starts.
    logic [4:0] wr_idx_q; // Header byte being written.
    logic [7:0] rd_idx_q; // Log byte being sent.
    logic log_valid_q; // A complete log is held and locked.
    logic vendor_q; // Sticky vendor status fault.
    logic hot_q; // Die is in the hot part of the window.
    logic [TICK_W-1:0] tick_cnt_q; // Up-time prescaler.
    logic [UPTIME_W-1:0] uptime_q; // Time since reset in steps.
    logic [15:0] vpk0_q, vpk1_q, ipk0_q, ipk1_q, vinpk_q; // Peak holds.
    logic peak_seen_q; // At least one reading since the last restart.
    flog_byte_t push_byte; // Byte offered to the buffer.
    logic buf_in_ready; // Buffer has room.

    // ============================================================
    // Command decode.
    // ============================================================
    wire die_fix_hot = flog_lin11_fix(tlm.die) > HOT_FIX; // Above the upper edge.
    wire die_fix_cool = flog_lin11_fix(tlm.die) < COOL_FIX; // Below the lower edge.
    wire cmd_force = cmd_valid && (cmd_code == FLOG_CMD_FORCE_STORE);
    wire cmd_rdout = cmd_valid && (cmd_code == FLOG_CMD_READOUT);
    wire cmd_erase = cmd_valid && (cmd_code == FLOG_CMD_ERASE);
    wire cmd_peak = cmd_valid && (cmd_code == FLOG_CMD_PEAK_RESET);
    // A forced store must be a plain write with no data and the die must
    // not be hot; a read of this command is never served.
    wire force_ok = cmd_force && !cmd_read && (cmd_data_len == 8'h00) && !hot_q; // R3 R5
    // The readout is a read only; it is refused while a store or a read is running.
    wire rdout_ok = cmd_rdout && cmd_read && (rd_q == RD_IDLE) && (store_q == ST_IDLE);
    // Erasing under a running store or read would tear the image.
    wire erase_ok = cmd_erase && !cmd_read && (rd_q == RD_IDLE) && (store_q == ST_IDLE);
    wire peak_ok = cmd_peak && !cmd_read;
    // A real fault and a forced store take one and the same store path.
    wire store_req = fault_event || force_ok; // R1
    // A held log is never overwritten, whichever way the store was asked.
    wire store_go = store_req && (store_q == ST_IDLE) && !log_valid_q; // R18
    wire tick = (tick_cnt_q == TICK_LAST); // One up-time step elapsed.
    wire push = (rd_q != RD_IDLE) && buf_in_ready; // A stream byte enters.

    assign cmd_rejected = cmd_valid && !(force_ok || rdout_ok || erase_ok || peak_ok);
    assign log_present = log_valid_q;
    assign store_busy = (store_q != ST_IDLE);
    assign vendor_status_fault = vendor_q;
    assign uptime_stamp = uptime_q;

    // ============================================================
    // Header image, byte 0 in the top bits.
    // ============================================================
    // The header is assembled from live values when a store starts.
    // Voltage peaks are passed as plain mantissas and the 11-bit words
    // keep their own exponent, so no field is rescaled here.
    wire [HDR_LEN*8-1:0] hdr_img = {
        PREFACE, // R8
        FACTORY_ID, // R9
        fault_source,
        uptime_q[7:0], uptime_q[15:8], uptime_q[23:16], // R10
        uptime_q[31:24], uptime_q[39:32], uptime_q[47:40], // R10
        vpk0_q, vpk1_q, // R11 R17
        ipk0_q, ipk1_q, // R12
        vinpk_q, // R13
        tlm.temp0, tlm.temp1, // R15
        tlm.die // R16
    };

    // Picks one header byte of an image by its byte number.
    function automatic logic [7:0] flog_hdr_pick(input logic [HDR_LEN*8-1:0] img,
                                                  input logic [7:0] idx);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < HDR_LEN; i++) begin
            if (idx == 8'(i)) begin
                r = img[(HDR_LEN-1-i)*8 +: 8];
            end
        end
        return r;
    endfunction : flog_hdr_pick

    // ============================================================
    // Up-time counter.
    // ============================================================
    // The prescaler and counter both restart at reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            tick_cnt_q <= '0;
            uptime_q <= '0;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
            uptime_q <= uptime_q + {47'h0, tick}; // R4
        end
    end

    // ============================================================
    // Die temperature hysteresis.
    // ============================================================
    // The five-degree gap stops a reading near the edge from toggling
    // the force store on and off at every sample.
    always_ff @(posedge clk) begin
        if (rst) begin
            hot_q <= 1'b0;
        end else if (tlm_valid && die_fix_hot) begin
            hot_q <= 1'b1; // R3
        end else if (tlm_valid && die_fix_cool) begin
            hot_q <= 1'b0; // R3
        end
    end

    // ============================================================
    // Peak holds.
    // ============================================================
    // The first reading after a restart loads every hold unconditionally;
    // later readings load only when larger.
    always_ff @(posedge clk) begin
        if (rst || peak_ok) begin
            peak_seen_q <= 1'b0; // R14
            vpk0_q <= 16'h0000;
            vpk1_q <= 16'h0000;
            ipk0_q <= 16'h0000;
            ipk1_q <= 16'h0000;
            vinpk_q <= 16'h0000;
        end else if (tlm_valid) begin
            peak_seen_q <= 1'b1;
            if (!peak_seen_q || tlm.vout0 > vpk0_q) begin
                vpk0_q <= tlm.vout0; // R14
            end
            if (!peak_seen_q || tlm.vout1 > vpk1_q) begin
                vpk1_q <= tlm.vout1;
            end
            if (!peak_seen_q || flog_lin11_fix(tlm.iout0) > flog_lin11_fix(ipk0_q)) begin
                ipk0_q <= tlm.iout0;
            end
            if (!peak_seen_q || flog_lin11_fix(tlm.iout1) > flog_lin11_fix(ipk1_q)) begin
                ipk1_q <= tlm.iout1;
            end
            if (!peak_seen_q || flog_lin11_fix(tlm.vin) > flog_lin11_fix(vinpk_q)) begin
                vinpk_q <= tlm.vin;
            end
        end
    end

    // ============================================================
    // Store sequence.
    // ============================================================
    // Bytes are written one per cycle, as a nonvolatile array would be
    // programmed; the log counts as present only once all are in.
    always_ff @(posedge clk) begin
        if (rst) begin
            store_q <= ST_IDLE;
            wr_idx_q <= 5'h00;
            snap_q <= '0;
        end else begin
            case (store_q)
                ST_IDLE: begin
                    if (store_go) begin
                        store_q <= ST_WRITE; // R1
                        snap_q <= hdr_img;
                        wr_idx_q <= 5'h00;
                    end
                end
                ST_WRITE: begin
                    wr_idx_q <= wr_idx_q + 5'h01;
                    if (wr_idx_q == HDR_LAST_IDX) begin
                        store_q <= ST_IDLE;
                    end
                end
                default: begin
                    store_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Header bytes land in the image during the write state.
    always_ff @(posedge clk) begin
        if (store_q == ST_WRITE) begin
            log_mem[wr_idx_q] <= flog_hdr_pick(snap_q, {3'h0, wr_idx_q});
        end
    end

    // Completion locks the log; only erase or reset clears the lock.
    always_ff @(posedge clk) begin
        if (rst) begin
            log_valid_q <= 1'b0;
        end else if (store_q == ST_WRITE && wr_idx_q == HDR_LAST_IDX) begin
            log_valid_q <= 1'b1; // R18
        end else if (erase_ok) begin
            log_valid_q <= 1'b0; // R19
        end
    end

    // ============================================================
    // Vendor status fault.
    // ============================================================
    // A set in the same cycle as a clear wins, so no store is missed.
    always_ff @(posedge clk) begin
        if (rst) begin
            vendor_q <= 1'b0;
        end else if (force_ok && log_enable) begin
            vendor_q <= 1'b1; // R2
        end else if (vendor_fault_clr) begin
            vendor_q <= 1'b0;
        end
    end

    // ============================================================
    // Block read producer.
    // ============================================================
    // The length byte goes first; an absent log ends the read there.
    always_comb begin
        push_byte.data = EMPTY_LEN_BYTE;
        push_byte.last = 1'b0;
        if (rd_q == RD_LEN) begin
            push_byte.data = log_valid_q ? LOG_LEN_BYTE : EMPTY_LEN_BYTE; // R6 R7
            push_byte.last = !log_valid_q; // R7
        end else if (rd_q == RD_DATA) begin
            // Event pages are not held by this block and read as fill.
            push_byte.data = (rd_idx_q < HDR_LEN_BYTE) ? log_mem[rd_idx_q[4:0]] : EVENT_FILL;
            push_byte.last = (rd_idx_q == LOG_LAST_IDX); // R6
        end
    end

    // Read state leaves idle on an accepted readout, then moves only when the buffer takes a byte.
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_q <= RD_IDLE;
            rd_idx_q <= 8'h00;
        end else begin
            case (rd_q)
                RD_IDLE: begin
                    if (rdout_ok) begin
                        rd_q <= RD_LEN;
                    end
                end
                RD_LEN: begin
                    if (push) begin
                        rd_q <= log_valid_q ? RD_DATA : RD_IDLE;
                        rd_idx_q <= 8'h00; // R20
                    end
                end
                RD_DATA: begin
                    if (push) begin
                        rd_idx_q <= rd_idx_q + 8'h01; // R20
                        if (push_byte.last) begin
                            rd_q <= RD_IDLE;
                        end
                    end
                end
                default: begin
                    rd_q <= RD_IDLE;
                end
            endcase
        end
    end

    // The buffer lets the reader stall without losing a byte.
    flog_skid u_skid (
        .clk(clk),
        .rst(rst),
        .in_data(push_byte),
        .in_valid(rd_q != RD_IDLE),
        .in_ready(buf_in_ready),
        .out_data(rd_byte),
        .out_valid(rd_valid),
        .out_ready(rd_ready)
    );

    // ============================================================
    // Checks.
    // ============================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_STORE_PATH: assert property ( // R1
        (force_ok && store_q == ST_IDLE && !log_valid_q) |=> (store_q == ST_WRITE)
    ) else $error("forced store did not start the store sequence");

    AST_VENDOR_SET: assert property ( // R2
        (force_ok && log_enable) |=> vendor_status_fault
    ) else $error("vendor status fault not raised by forced store");

    AST_HOT_BLOCK: assert property ( // R3
        (hot_q && cmd_force) |-> (!force_ok && cmd_rejected)
    ) else $error("forced store accepted while die hot");

    AST_UPTIME_STEP: assert property ( // R4
        tick |=> (uptime_q == $past(uptime_q) + 48'h1)
    ) else $error("up-time counter missed a step");

    AST_FORCE_NODATA: assert property ( // R5
        (cmd_force && (cmd_read || cmd_data_len != 8'h00)) |-> (!force_ok && cmd_rejected)
    ) else $error("forced store accepted with data or as a read");

    AST_LEN_FULL: assert property ( // R6
        (push && rd_q == RD_LEN && log_valid_q) |-> (push_byte.data == LOG_LEN_BYTE)
    ) else $error("present log did not report full length");

    AST_LEN_EMPTY: assert property ( // R7
        (push && rd_q == RD_LEN && !log_valid_q) |=> (rd_q == RD_IDLE)
    ) else $error("absent log read did not end after length");

    AST_LOCKED: assert property ( // R18
        (log_valid_q && !erase_ok) |=> (store_q == ST_IDLE && log_valid_q)
    ) else $error("locked log was disturbed");

    AST_ERASE: assert property ( // R19
        erase_ok |=> !log_present
    ) else $error("erase left a log present");

    AST_ORDER: assert property ( // R20
        (push && rd_q == RD_DATA && !push_byte.last) |=> (rd_idx_q == $past(rd_idx_q) + 8'h01)
    ) else $error("log bytes out of order");

    AST_PEAK_RESTART: assert property ( // R14
        peak_ok |=> (vpk0_q == 16'h0000 && !peak_seen_q)
    ) else $error("peak hold did not restart");

    COV_FORCE: cover property (force_ok ##[1:40] log_present);
    COV_FULL_READ: cover property (push && push_byte.last && rd_q == RD_DATA);
    COV_STALL: cover property (rd_valid && !rd_ready && !buf_in_ready);

endmodule : flog_core

// ===== testbench/flog_host.sv
`timescale 1ns/1ns
// ============================================================
// Host reader that takes stream bytes and stalls at random.
// ============================================================
module flog_host
    import flog_pkg::*;
(
    input wire logic clk,
    input flog_byte_t rd_byte,
    input wire logic rd_valid,
    output logic rd_ready
);
    logic [8:0] q[$]; // Bytes taken, each with its last flag.
    initial rd_ready = 1'b0;
    // Stalling about a third of the cycles keeps the buffer's second entry busy.
    always @(negedge clk) rd_ready <= ($urandom_range(2) != 0);
    // A byte is taken only at an edge where both sides agree.
    always @(posedge clk) begin
        if (rd_valid && rd_ready) begin
            q.push_back(rd_byte);
        end
    end
endmodule : flog_host

// ===== testbench/fault_log_store_and_header_tb_top.sv
`timescale 1ns/1ns
// ============================================================
// Self-checking bench with a queue model of the log image.
// ============================================================
module fault_log_store_and_header_tb_top
    import flog_pkg::*;
;
    localparam logic [15:0] PRE = 16'h464c; // Arbitrary preface value.
    localparam logic [15:0] FID = 16'h1234; // Arbitrary identifier value.
    logic clk = 1'b0, rst = 1'b1, tlm_valid = 1'b0, fault_event = 1'b0;
    logic cmd_valid = 1'b0, cmd_read = 1'b0, log_enable = 1'b0, vendor_fault_clr = 1'b0;
    logic [7:0] cmd_data_len = 8'h00, fault_source = 8'h00;
    flog_cmd_t cmd_code = FLOG_CMD_FORCE_STORE;
    flog_tlm_t tlm = '0;
    logic vendor_status_fault, cmd_rejected, log_present, store_busy, rd_valid, rd_ready;
    logic [UPTIME_W-1:0] uptime_stamp;
    flog_byte_t rd_byte;
    int fails = 0, n_checks = 0, cyc = 0, ts = 0;
    logic [15:0] pk[5] = '{default: 16'h0000}; // Model of the five peak holds.
    logic [7:0] ex[$]; // Expected stream, length byte first.
    always #4 clk = ~clk;
    // Cycles since reset; a short tick of 4 makes the stamp easy to predict.
    always @(posedge clk) cyc <= rst ? 0 : cyc + 1;
    flog_core #(.TICK_CYCLES(4), .PREFACE(PRE), .FACTORY_ID(FID)) dut (
        .clk(clk), .rst(rst), .tlm(tlm), .tlm_valid(tlm_valid),
        .fault_event(fault_event), .fault_source(fault_source), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_read(cmd_read), .cmd_data_len(cmd_data_len),
        .log_enable(log_enable), .vendor_fault_clr(vendor_fault_clr),
        .vendor_status_fault(vendor_status_fault), .cmd_rejected(cmd_rejected),
        .log_present(log_present), .store_busy(store_busy), .uptime_stamp(uptime_stamp),
        .rd_byte(rd_byte), .rd_valid(rd_valid), .rd_ready(rd_ready));
    flog_host host (.clk(clk), .rd_byte(rd_byte), .rd_valid(rd_valid), .rd_ready(rd_ready));
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    task chk(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // Positive words with a zero exponent, so the plain maximum is the peak.
    task sample(input int top, input logic [15:0] die);
        logic [15:0] w[8];
        for (int i = 0; i < 8; i++) w[i] = 16'($urandom_range(top));
        w[7] = die;
        for (int i = 0; i < 5; i++) if (w[i] > pk[i]) pk[i] = w[i];
        tlm = {w[0], w[1], w[2], w[3], w[4], w[5], w[6], w[7]};
        tlm_valid = 1'b1;
        tick(1);
        tlm_valid = 1'b0;
    endtask : sample
    task cmd(input flog_cmd_t c, input logic rd, input logic [7:0] len, input logic rej);
        cmd_code = c;
        cmd_read = rd;
        cmd_data_len = len;
        cmd_valid = 1'b1;
        ts = cyc / 4;
        #1 chk(cmd_rejected, rej);
        tick(1);
        cmd_valid = 1'b0;
    endtask : cmd
    task wait_idle;
        int k;
        for (k = 0; k < 100 && store_busy !== 1'b0; k++) tick(1);
        if (k == 100) begin fails++; complete_run; end
    endtask : wait_idle
    // Header image as the store should capture it; event pages read as fill.
    task mk(input logic [7:0] src);
        logic [15:0] wd[8];
        wd = '{pk[0], pk[1], pk[2], pk[3], pk[4], tlm.temp0, tlm.temp1, tlm.die};
        ex = {LOG_LEN_BYTE, PRE[15:8], PRE[7:0], FID[15:8], FID[7:0], src};
        for (int i = 0; i < 6; i++) ex.push_back(8'(ts >> (8 * i)));
        for (int i = 0; i < 8; i++) ex = {ex, wd[i][15:8], wd[i][7:0]};
        while (ex.size() < LOG_LEN + 1) ex.push_back(EVENT_FILL);
    endtask : mk
    // The stamp is judged exactly against the image the store captured, since a
    // later command moves ts on while a locked log keeps its old stamp.
    task rd_log(input int n);
        logic [47:0] g;
        g = '0;
        host.q = {};
        cmd(FLOG_CMD_READOUT, 1'b1, 8'h00, 1'b0);
        for (int k = 0; k < 2000 && host.q.size() < n; k++) tick(1);
        // A few cycles more, so that a byte sent once too often is caught.
        tick(4);
        if (host.q.size() != n) begin fails++; complete_run; end
        for (int i = 0; i < n; i++) begin
            if (i > 5 && i < 12) g = g | (48'(host.q[i][8:1]) << (8 * (i - 6)));
            chk(host.q[i][8:1], ex[i]);
            chk(host.q[i][0], i == n - 1);
        end
        if (n > 1) chk(g, {ex[11], ex[10], ex[9], ex[8], ex[7], ex[6]});
        $display("read of %0d bytes done", n);
    endtask : rd_log
    initial begin
        void'($urandom(5));
        tick(10);
        rst = 1'b0;
        tick(1);
        chk(uptime_stamp, 48'h0);
        ex = {EMPTY_LEN_BYTE};
        rd_log(1);
        repeat (20) sample(16'h3ff, 16'h0032);
        cmd(FLOG_CMD_FORCE_STORE, 1'b1, 8'h00, 1'b1);
        cmd(FLOG_CMD_FORCE_STORE, 1'b0, 8'h01, 1'b1);
        log_enable = 1'b1;
        fault_source = 8'h5a;
        cmd(FLOG_CMD_FORCE_STORE, 1'b0, 8'h00, 1'b0);
        chk(store_busy, 1'b1);
        chk(vendor_status_fault, 1'b1);
        mk(fault_source);
        wait_idle;
        chk(log_present, 1'b1);
        rd_log(LOG_LEN + 1);
        vendor_fault_clr = 1'b1;
        tick(1);
        vendor_fault_clr = 1'b0;
        repeat (5) sample(16'h3ff, 16'h0040);
        cmd(FLOG_CMD_FORCE_STORE, 1'b0, 8'h00, 1'b0);
        chk(vendor_status_fault, 1'b1);
        wait_idle;
        rd_log(LOG_LEN + 1);
        cmd(FLOG_CMD_ERASE, 1'b0, 8'h00, 1'b0);
        chk(log_present, 1'b0);
        ex = {EMPTY_LEN_BYTE};
        rd_log(1);
        cmd(FLOG_CMD_PEAK_RESET, 1'b0, 8'h00, 1'b0);
        pk = '{default: 16'h0000};
        repeat (5) sample(16'h00f, 16'h003c);
        log_enable = 1'b0;
        vendor_fault_clr = 1'b1;
        tick(1);
        vendor_fault_clr = 1'b0;
        fault_event = 1'b1;
        ts = cyc / 4;
        tick(1);
        fault_event = 1'b0;
        mk(fault_source);
        wait_idle;
        chk(vendor_status_fault, 1'b0);
        rd_log(LOG_LEN + 1);
        cmd(FLOG_CMD_ERASE, 1'b0, 8'h00, 1'b0);
        sample(16'h00f, 16'h0083);
        cmd(FLOG_CMD_FORCE_STORE, 1'b0, 8'h00, 1'b1);
        sample(16'h00f, 16'h007f);
        cmd(FLOG_CMD_FORCE_STORE, 1'b0, 8'h00, 1'b1);
        sample(16'h00f, 16'h007c);
        cmd(FLOG_CMD_FORCE_STORE, 1'b0, 8'h00, 1'b0);
        chk(store_busy, 1'b1);
        chk(vendor_status_fault, 1'b0);
        $display("temperature window test done");
        complete_run;
    end
endmodule : fault_log_store_and_header_tb_top
